// >>> rtl/stu_thermostat_ui.sv
`include "stu_defines.svh"

// Functional notes
// - while idle, drive all columns low and sample the three rows until one goes low.
// - after a press, pull one column low at a time until the row matches.
// - keep three cooling and three heating set points.
// - seven records of temperature, hour, minute; record zero is current.
// - display data leaves on serial clock and data only, no select.
// - resend display every second, every keystroke and each display step.
// - normal mode shows current hours, minutes and temperature.
// - normal mode toggles the point after the hour digits each second.
// - zero key from normal enters display mode at first cooling set point.
// - five seconds without a key in display mode returns to normal.
// - further zero presses step cooling two, three, then heating one to three.
// - time or temp key enters programming; display echoes typed digits.
// - measure thermistor square-wave period and sample it every two seconds.
// - convert period to Fahrenheit by table spanning 32 to 122.
// - converted temperature goes into the current record.
// - 984 ms reload plus 16 ms processing gives one second; roll time over.
module stu_thermostat_ui #(
    parameter int P_CYC_PER_MS = `STU_MS_NS / `STU_CLK_NS
) (
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic [2:0] i_row_n,
    input  wire logic       i_therm,
    output logic      [3:0] o_col_n,
    output logic            o_lcd_sclk,
    output logic            o_lcd_sdo,
    output logic            o_key_valid,
    output logic      [3:0] o_key_code
);
    localparam int HALF_CYC = (`STU_SCLK_HALF_NS + `STU_CLK_NS - 1) / `STU_CLK_NS;
    localparam logic [15:0] MS_LAST   = 16'(P_CYC_PER_MS - 1);
    localparam logic [9:0]  SEC_LAST  = 10'(`STU_TICK_RELOAD_MS + `STU_PROC_MS - 1);
    localparam logic [12:0] TMO_LAST  = 13'(`STU_DISP_TMO_MS - 1);
    localparam logic [2:0]  HALF_LAST = 3'(HALF_CYC - 1);
    localparam logic [16*`STU_RTAB_N-1:0] RTAB = `STU_RTAB;

    generate
        if (P_CYC_PER_MS < 8 || P_CYC_PER_MS > 65536) begin : g_bad_ms
            $error("P_CYC_PER_MS out of range");
        end
    endgenerate

    stu_pkg::stu_state_t s;
    stu_pkg::stu_state_t n;
    logic                sec_tick;

    function automatic logic [7:0] seg(input logic [3:0] d);
        case (d)
            4'h0:    return 8'hd7;
            4'h1:    return 8'h06;
            4'h2:    return 8'he3;
            4'h3:    return 8'ha7;
            4'h4:    return 8'h36;
            4'h5:    return 8'hb5;
            4'h6:    return 8'hf5;
            4'h7:    return 8'h07;
            4'h8:    return 8'hf7;
            4'h9:    return 8'h37;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [3:0] key_lookup(input logic [1:0] r, input logic [1:0] c);
        case ({r, c})
            4'h0:    return 4'h7;
            4'h1:    return 4'h8;
            4'h2:    return 4'h9;
            4'h3:    return `STU_KEY_TIME;
            4'h4:    return 4'h4;
            4'h5:    return 4'h5;
            4'h6:    return 4'h6;
            4'h7:    return `STU_KEY_TEMP;
            4'h8:    return 4'h1;
            4'h9:    return 4'h2;
            4'ha:    return 4'h3;
            default: return `STU_KEY_ZERO;
        endcase
    endfunction

    // count of table entries above the period gives the step above the coldest point
    function automatic logic [6:0] therm_to_f(input logic [15:0] p);
        int cnt;
        cnt = 0;
        for (int i = 0; i < `STU_RTAB_N; i++) begin
            if (RTAB[(`STU_RTAB_N - 1 - i) * 16 +: 16] > p) begin
                cnt = cnt + 1;
            end
        end
        if (cnt > `STU_RTAB_N - 1) begin
            cnt = `STU_RTAB_N - 1;
        end
        return 7'(`STU_TEMP_MIN_F
                  + (cnt * (`STU_TEMP_MAX_F - `STU_TEMP_MIN_F)) / (`STU_RTAB_N - 1));
    endfunction

    function automatic logic [7:0] split(input logic [6:0] v);
        logic [6:0] t;
        t = v / 7'd10;
        return {4'(t % 7'd10), 4'(v % 7'd10)};
    endfunction

    function automatic logic [6:0] bcd2(input logic [3:0] t, input logic [3:0] u);
        return 7'(t) * 7'd10 + 7'(u);
    endfunction

    function automatic logic [47:0] build_frame(input logic [23:0] dig, input logic dp);
        logic [47:0] f;
        logic [7:0]  b;
        f = '0;
        for (int i = 0; i < `STU_NUM_DIGITS; i++) begin
            b = seg(dig[i*4 +: 4]);
            if (i == `STU_DP_DIGIT && dp) begin
                b = b | `STU_DP_BIT;
            end
            f[(`STU_NUM_DIGITS - 1 - i) * 8 +: 8] = b;
        end
        return f;
    endfunction

    assign sec_tick = s.ms_tick && (s.sec_ms == SEC_LAST);

    always_comb begin
        stu_pkg::stu_rec_t r;
        logic [23:0]       dig;
        logic [15:0]       edig;
        logic              dp;
        logic [1:0]        row;
        n = s;
        r = s.rec[s.sel];
        dig = '0;
        edig = '0;
        dp = 1'b0;
        row = 2'h0;
        n.row_s1 = i_row_n;
        n.row_s2 = s.row_s1;
        n.th_s1 = i_therm;
        n.th_s2 = s.th_s1;
        n.th_prev = s.th_s2;
        n.key_valid = 1'b0;
        n.ms_tick = (s.ms_cnt == MS_LAST);
        n.ms_cnt = n.ms_tick ? 16'h0 : s.ms_cnt + 16'h1;
        if (!s.row_s2[0]) begin
            row = 2'h0;
        end else if (!s.row_s2[1]) begin
            row = 2'h1;
        end else begin
            row = 2'h2;
        end

        // keypad scanner, stepped once per millisecond
        if (s.ms_tick) begin
            case (s.scan)
                stu_pkg::SCAN_IDLE: begin
                    n.col_n = 4'h0;
                    if (s.row_s2 != 3'h7) begin
                        n.scan = stu_pkg::SCAN_COLS;
                        n.col_idx = 2'h0;
                        n.col_n = 4'he;
                    end
                end
                stu_pkg::SCAN_COLS: begin
                    if (s.row_s2 != 3'h7) begin
                        n.key_valid = 1'b1;
                        n.key_code = key_lookup(row, s.col_idx);
                        n.scan = stu_pkg::SCAN_RELEASE;
                        n.col_n = 4'h0;
                    end else if (s.col_idx == 2'h3) begin
                        n.scan = stu_pkg::SCAN_IDLE;
                        n.col_n = 4'h0;
                    end else begin
                        n.col_idx = s.col_idx + 2'h1;
                        n.col_n = ~(4'h1 << (s.col_idx + 2'h1));
                    end
                end
                stu_pkg::SCAN_RELEASE: begin
                    if (s.row_s2 == 3'h7) begin
                        n.scan = stu_pkg::SCAN_IDLE;
                    end
                end
                default: begin
                    n.scan = stu_pkg::SCAN_IDLE;
                    n.col_n = 4'h0;
                end
            endcase
        end

        // one-second clock and time roll-over
        if (s.ms_tick) begin
            n.sec_ms = sec_tick ? 10'h0 : s.sec_ms + 10'h1;
        end
        if (sec_tick) begin
            n.two_s = !s.two_s;
            if (s.mode == stu_pkg::MODE_NORMAL) begin
                n.point_on = !s.point_on;
            end
            if (s.seconds == 6'(`STU_SEC_PER_MIN - 1)) begin
                n.seconds = 6'h0;
                if (s.rec[0].minutes == 6'(`STU_MIN_PER_HR - 1)) begin
                    n.rec[0].minutes = 6'h0;
                    if (s.rec[0].hours == 5'(`STU_HR_PER_DAY - 1)) begin
                        n.rec[0].hours = 5'h0;
                        n.days = s.days + 8'h1;
                    end else begin
                        n.rec[0].hours = s.rec[0].hours + 5'h1;
                    end
                end else begin
                    n.rec[0].minutes = s.rec[0].minutes + 6'h1;
                end
            end else begin
                n.seconds = s.seconds + 6'h1;
            end
            if (s.two_s) begin
                n.rec[0].temp = therm_to_f(s.per_q);
            end
            n.refresh = 1'b1;
        end

        // thermistor period, counted between rising edges
        if (s.th_s2 && !s.th_prev) begin
            n.per_q = s.per_cnt;
            n.per_cnt = 16'h0;
        end else if (s.per_cnt != 16'hffff) begin
            n.per_cnt = s.per_cnt + 16'h1;
        end

        // mode sequencing
        if (s.mode == stu_pkg::MODE_DISPLAY && s.ms_tick && !s.key_valid) begin
            n.disp_ms = s.disp_ms + 13'h1;
            if (s.disp_ms == TMO_LAST) begin
                n.mode = stu_pkg::MODE_NORMAL;
                n.sel = 3'h0;
                n.refresh = 1'b1;
            end
        end
        if (s.key_valid) begin
            n.refresh = 1'b1;
            n.disp_ms = 13'h0;
            case (s.mode)
                stu_pkg::MODE_NORMAL, stu_pkg::MODE_DISPLAY: begin
                    if (s.key_code == `STU_KEY_ZERO) begin
                        if (s.mode == stu_pkg::MODE_NORMAL) begin
                            n.mode = stu_pkg::MODE_DISPLAY;
                            n.sel = 3'h1;
                        end else if (s.sel == 3'(2 * `STU_NUM_SETPT)) begin
                            n.mode = stu_pkg::MODE_NORMAL;
                            n.sel = 3'h0;
                        end else begin
                            n.sel = s.sel + 3'h1;
                        end
                    end else if (s.key_code == `STU_KEY_TIME
                                 || s.key_code == `STU_KEY_TEMP) begin
                        n.mode = stu_pkg::MODE_PROG;
                        n.prog_temp = (s.key_code == `STU_KEY_TEMP);
                        n.target = s.sel;
                        n.ent_cnt = 3'h0;
                    end
                end
                stu_pkg::MODE_PROG: begin
                    if (s.key_code <= 4'h9) begin
                        n.ent = {s.ent[11:0], s.key_code};
                        n.ent_cnt = s.ent_cnt + 3'h1;
                        if (s.prog_temp && s.ent_cnt + 3'h1 == `STU_TEMP_DIGITS) begin
                            n.rec[s.target].temp = bcd2(s.ent[3:0], s.key_code);
                            n.mode = stu_pkg::MODE_NORMAL;
                            n.sel = 3'h0;
                        end else if (!s.prog_temp
                                     && s.ent_cnt + 3'h1 == `STU_TIME_DIGITS) begin
                            if (bcd2(s.ent[11:8], s.ent[7:4]) < 7'(`STU_HR_PER_DAY)
                                && bcd2(s.ent[3:0], s.key_code) < 7'(`STU_MIN_PER_HR)) begin
                                n.rec[s.target].hours = 5'(bcd2(s.ent[11:8], s.ent[7:4]));
                                n.rec[s.target].minutes = 6'(bcd2(s.ent[3:0], s.key_code));
                            end
                            n.mode = stu_pkg::MODE_NORMAL;
                            n.sel = 3'h0;
                        end
                    end
                end
                default: begin
                    n.mode = stu_pkg::MODE_NORMAL;
                end
            endcase
        end

        // display content for the current mode
        for (int i = 0; i < 4; i++) begin
            edig[i*4 +: 4] = (3'(i) < s.ent_cnt) ? s.ent[i*4 +: 4] : 4'hf;
        end
        case (s.mode)
            stu_pkg::MODE_PROG: begin
                dig = s.prog_temp ? {16'hffff, edig[7:0]} : {edig, 8'hff};
            end
            stu_pkg::MODE_DISPLAY: begin
                dig = {split(7'(r.hours)), split(7'(r.minutes)), split(r.temp)};
                dp = 1'b1;
            end
            default: begin
                dig = {split(7'(s.rec[0].hours)), split(7'(s.rec[0].minutes)),
                       split(s.rec[0].temp)};
                dp = s.point_on;
            end
        endcase

        // serial display link, clock idles low, data moves on the falling edge
        case (s.lcd)
            stu_pkg::LCD_IDLE: begin
                n.sclk = 1'b0;
                if (s.refresh) begin
                    n.sh = build_frame(dig, dp);
                    n.sdo = n.sh[47];
                    n.bit_cnt = 6'(`STU_NUM_DIGITS * 8);
                    n.half_cnt = 3'h0;
                    n.lcd = stu_pkg::LCD_SHIFT;
                    // a request raised in this same cycle stays pending
                    n.refresh = s.key_valid || sec_tick
                                || (s.mode == stu_pkg::MODE_DISPLAY && s.ms_tick
                                    && s.disp_ms == TMO_LAST);
                end
            end
            stu_pkg::LCD_SHIFT: begin
                n.half_cnt = s.half_cnt + 3'h1;
                if (s.half_cnt == HALF_LAST) begin
                    n.half_cnt = 3'h0;
                    if (!s.sclk) begin
                        n.sclk = 1'b1;
                    end else begin
                        n.sclk = 1'b0;
                        n.sh = {s.sh[46:0], 1'b0};
                        n.sdo = s.sh[46];
                        n.bit_cnt = s.bit_cnt - 6'h1;
                        if (s.bit_cnt == 6'h1) begin
                            n.sdo = 1'b0;
                            n.lcd = stu_pkg::LCD_IDLE;
                        end
                    end
                end
            end
            default: begin
                n.lcd = stu_pkg::LCD_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_col_n = s.col_n;
    assign o_lcd_sclk = s.sclk;
    assign o_lcd_sdo = s.sdo;
    assign o_key_valid = s.key_valid;
    assign o_key_code = s.key_code;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_zero_key;
        s.key_valid && s.key_code == `STU_KEY_ZERO;
    endsequence

    property p_idle_cols;
        s.scan == stu_pkg::SCAN_IDLE |-> s.col_n == 4'h0;
    endproperty
    a_idle_cols: assert property (p_idle_cols) else $error("columns not low in idle");

    property p_one_col;
        s.scan == stu_pkg::SCAN_COLS |-> $onehot(~s.col_n);
    endproperty
    a_one_col: assert property (p_one_col) else $error("not one column low");

    property p_release;
        s.scan == stu_pkg::SCAN_RELEASE && s.row_s2 != 3'h7 |=> !s.key_valid
            && s.scan == stu_pkg::SCAN_RELEASE;
    endproperty
    a_release: assert property (p_release) else $error("rescan before release");

    property p_sdo_stable;
        $past(s.lcd) == stu_pkg::LCD_SHIFT && $changed(s.sdo) |-> $fell(s.sclk);
    endproperty
    a_sdo_stable: assert property (p_sdo_stable) else $error("data moved off falling edge");

    property p_key_refresh;
        s.key_valid |=> s.refresh || s.lcd == stu_pkg::LCD_SHIFT;
    endproperty
    a_key_refresh: assert property (p_key_refresh) else $error("key did not refresh");

    property p_enter_display;
        s_zero_key ##0 s.mode == stu_pkg::MODE_NORMAL |=>
            s.mode == stu_pkg::MODE_DISPLAY && s.sel == 3'h1;
    endproperty
    a_enter_display: assert property (p_enter_display) else $error("display entry wrong");

    property p_step;
        s_zero_key ##0 s.mode == stu_pkg::MODE_DISPLAY && s.sel < 3'h6 |=>
            s.sel == $past(s.sel) + 3'h1;
    endproperty
    a_step: assert property (p_step) else $error("set point step wrong");

    property p_timeout;
        s.mode == stu_pkg::MODE_DISPLAY && s.ms_tick && s.disp_ms == TMO_LAST && !s.key_valid
            |=> s.mode == stu_pkg::MODE_NORMAL;
    endproperty
    a_timeout: assert property (p_timeout) else $error("display timeout missed");

    property p_temp_sample;
        sec_tick && s.two_s |=> s.rec[0].temp == therm_to_f($past(s.per_q));
    endproperty
    a_temp_sample: assert property (p_temp_sample) else $error("temperature not stored");

    property p_blink;
        sec_tick && s.mode == stu_pkg::MODE_NORMAL |=> s.point_on != $past(s.point_on);
    endproperty
    a_blink: assert property (p_blink) else $error("point did not toggle");

    property p_second;
        sec_tick |=> s.seconds != $past(s.seconds) ##1 s.sec_ms == 10'h0;
    endproperty
    a_second: assert property (p_second) else $error("second not counted");
endmodule

// >>> inc/stu_defines.svh
`ifndef STU_DEFINES_SVH
`define STU_DEFINES_SVH

`define STU_CLK_NS          100
`define STU_MS_NS           1000000
`define STU_SCLK_HALF_NS    400
`define STU_TICK_RELOAD_MS  984
`define STU_PROC_MS         16
`define STU_DISP_TMO_MS     5000
`define STU_TEMP_MIN_F      32
`define STU_TEMP_MAX_F      122
`define STU_SEC_PER_MIN     60
`define STU_MIN_PER_HR      60
`define STU_HR_PER_DAY      24
`define STU_NUM_SETPT       3
`define STU_NUM_REC         7
`define STU_NUM_DIGITS      6
`define STU_DP_BIT          8'h08
`define STU_DP_DIGIT        4
`define STU_KEY_ZERO        4'h0
`define STU_KEY_TIME        4'ha
`define STU_KEY_TEMP        4'hb
`define STU_TIME_DIGITS     3'h4
`define STU_TEMP_DIGITS     3'h2
`define STU_RTAB_N          50
`define STU_RTAB {16'h5840, 16'h54ae, 16'h51ed, 16'h4eef, 16'h4c0d, 16'h4945, 16'h4698, \
    16'h4404, 16'h4188, 16'h3f23, 16'h3cd5, 16'h3a9c, 16'h3878, 16'h3668, 16'h346c, \
    16'h3281, 16'h30a9, 16'h2ee2, 16'h2d2c, 16'h2b85, 16'h29ee, 16'h2866, 16'h26ed, \
    16'h2581, 16'h2422, 16'h22d0, 16'h218b, 16'h2051, 16'h1f23, 16'h1e00, 16'h1ce7, \
    16'h1bd9, 16'h1ad5, 16'h19da, 16'h18e8, 16'h17ff, 16'h171f, 16'h1647, 16'h1576, \
    16'h14ae, 16'h13ec, 16'h1332, 16'h127e, 16'h11d2, 16'h112b, 16'h108a, 16'h0ff0, \
    16'h0f5b, 16'h0ecb, 16'h0ddd}

`endif

// >>> inc/stu_pkg.sv
`include "stu_defines.svh"

package stu_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'b00,
        MODE_DISPLAY = 2'b01,
        MODE_PROG    = 2'b10
    } stu_mode_t;

    typedef enum logic [1:0] {
        SCAN_IDLE    = 2'b00,
        SCAN_COLS    = 2'b01,
        SCAN_RELEASE = 2'b10
    } stu_scan_t;

    typedef enum logic [0:0] {
        LCD_IDLE  = 1'b0,
        LCD_SHIFT = 1'b1
    } stu_lcd_t;

    typedef struct packed {
        logic [6:0] temp;
        logic [5:0] minutes;
        logic [4:0] hours;
    } stu_rec_t;

    typedef struct packed {
        logic [2:0]  row_s1;
        logic [2:0]  row_s2;
        logic        th_s1;
        logic        th_s2;
        logic        th_prev;
        stu_scan_t   scan;
        logic [1:0]  col_idx;
        logic [3:0]  col_n;
        logic        key_valid;
        logic [3:0]  key_code;
        logic [15:0] ms_cnt;
        logic        ms_tick;
        logic [9:0]  sec_ms;
        logic [12:0] disp_ms;
        logic [5:0]  seconds;
        logic [7:0]  days;
        logic        two_s;
        stu_mode_t   mode;
        logic [2:0]  sel;
        logic        prog_temp;
        logic [2:0]  target;
        logic [15:0] ent;
        logic [2:0]  ent_cnt;
        stu_rec_t [`STU_NUM_REC-1:0] rec;
        logic [15:0] per_cnt;
        logic [15:0] per_q;
        logic        point_on;
        logic        refresh;
        stu_lcd_t    lcd;
        logic [47:0] sh;
        logic [5:0]  bit_cnt;
        logic [2:0]  half_cnt;
        logic        sclk;
        logic        sdo;
    } stu_state_t;
endpackage

// >>> tb/stu_partner.sv
module stu_partner #(
    parameter int P_THERM_HALF = 1664
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic [3:0]  i_col_n,
    input  wire logic        i_sclk,
    input  wire logic        i_sdo,
    input  wire logic        i_press,
    input  wire logic [1:0]  i_row_sel,
    input  wire logic [1:0]  i_col_sel,
    output logic      [2:0]  o_row_n,
    output logic             o_therm,
    output logic      [47:0] o_frame,
    output int               o_frame_cnt
);
    timeunit 1ns;
    timeprecision 1ns;

    logic        sclk_q;
    logic [47:0] sh;
    int          nbits;

    // rows are pulled up; a held key shorts its row to its column
    always_comb begin
        for (int r = 0; r < 3; r++) begin
            o_row_n[r] = !(i_press && (i_row_sel == 2'(r)) && !i_col_n[i_col_sel]);
        end
    end

    // thermistor oscillator, half period in system clock cycles
    initial begin
        o_therm = 1'b0;
        forever #(P_THERM_HALF * 100) o_therm = ~o_therm;
    end

    // display driver: shifts data on the serial clock rising edge only
    always @(posedge i_mclk) begin
        sclk_q <= i_sclk;
        if (i_rst) begin
            nbits = 0;
            o_frame_cnt <= 0;
        end else if (i_sclk && !sclk_q) begin
            sh = {sh[46:0], i_sdo};
            if (nbits == 47) begin
                o_frame <= sh;
                o_frame_cnt <= o_frame_cnt + 1;
                nbits = 0;
            end else begin
                nbits = nbits + 1;
            end
        end
    end
endmodule

// >>> tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk, rst, press, therm, sclk, sdo, key_valid;
    logic [2:0]  row_n;
    logic [3:0]  col_n, key_code;
    logic [1:0]  row_sel, col_sel;
    logic [47:0] frame;
    int          fcnt, num_errors, num_checks;
    logic [3:0]  kmap [3][4] = '{'{4'h7, 4'h8, 4'h9, 4'ha}, '{4'h4, 4'h5, 4'h6, 4'hb},
                                 '{4'h1, 4'h2, 4'h3, 4'h0}};

    stu_thermostat_ui #(.P_CYC_PER_MS(8)) stu_thermostat_ui_inst (
        .i_mclk(mclk), .i_sys_rst(rst), .i_row_n(row_n), .i_therm(therm), .o_col_n(col_n),
        .o_lcd_sclk(sclk), .o_lcd_sdo(sdo), .o_key_valid(key_valid), .o_key_code(key_code));

    stu_partner stu_partner_inst (
        .i_mclk(mclk), .i_rst(rst), .i_col_n(col_n), .i_sclk(sclk), .i_sdo(sdo),
        .i_press(press), .i_row_sel(row_sel), .i_col_sel(col_sel), .o_row_n(row_n),
        .o_therm(therm), .o_frame(frame), .o_frame_cnt(fcnt));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task summarize;
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] fb(input int i);
        return frame[47-8*i -: 8];
    endfunction

    // one press: decoded once while held, then released
    task press_key(input logic [3:0] code);
        int k;
        int hits;
        hits = 0;
        @(negedge mclk);
        for (k = 0; k < 12; k++) begin
            if (kmap[k/4][k%4] === code) begin
                row_sel = 2'(k / 4);
                col_sel = 2'(k % 4);
            end
        end
        press = 1'b1;
        for (k = 0; k < 100 && key_valid !== 1'b1; k++) @(negedge mclk);
        chk({7'h0, key_valid}, 8'h01);
        chk({4'h0, key_code}, {4'h0, code});
        if (key_valid !== 1'b1) summarize;
        for (k = 0; k < 80; k++) begin
            @(negedge mclk);
            if (key_valid === 1'b1) hits++;
        end
        chk(8'(hits), 8'h00);
        press = 1'b0;
        repeat (400) @(negedge mclk);
    endtask

    task wait_frame(input int since, input int bound);
        int k;
        for (k = 0; k < bound && fcnt == since; k++) @(negedge mclk);
        if (fcnt == since) begin
            num_errors++;
            $display("Error at %0t: no display frame", $time);
            summarize;
        end
    endtask

    task do_reset;
        @(negedge mclk);
        rst = 1'b1;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
    endtask

    task scan_all_keys;
        chk({4'h0, col_n}, 8'h00);
        for (int k = 0; k < 12; k++) press_key(kmap[k/4][k%4]);
    endtask

    // set 12:34, then watch time, point and temperature on second frames
    task normal_mode;
        logic [7:0] p;
        press_key(4'ha);
        press_key(4'h1);
        press_key(4'h2);
        press_key(4'h3);
        press_key(4'h4);
        repeat (1000) @(negedge mclk);
        wait_frame(fcnt, 9000);
        chk(fb(2), 8'h36);
        chk(fb(3), 8'ha7);
        chk(fb(4) & 8'hf7, 8'he3);
        chk(fb(5), 8'h06);
        p = fb(4) & 8'h08;
        wait_frame(fcnt, 9000);
        chk(fb(4) & 8'h08, p ^ 8'h08);
        wait_frame(fcnt, 9000);
        chk(fb(0), 8'he3);
        chk(fb(1), 8'he3);
    endtask

    task display_mode;
        int c;
        int k;
        c = fcnt;
        press_key(4'h0);
        wait_frame(c, 1000);
        chk(fb(4), 8'hdf);
        chk(fb(0), 8'hd7);
        c = fcnt;
        press_key(4'h0);
        wait_frame(c, 1000);
        chk(fb(4), 8'hdf);
        press_key(4'hb);
        c = fcnt;
        press_key(4'h2);
        wait_frame(c, 1000);
        chk(fb(0), 8'he3);
        chk(fb(1), 8'h00);
        press_key(4'h5);
        press_key(4'h0);
        c = fcnt;
        press_key(4'h0);
        wait_frame(c, 1000);
        chk(fb(0), 8'hb5);
        chk(fb(1), 8'he3);
        c = fcnt;
        for (k = 0; k < 60000; k++) begin
            @(negedge mclk);
            if (fcnt != c && fb(0) === 8'he3) break;
            c = fcnt;
        end
        chk({7'h0, k >= 39000 && k < 41500}, 8'h01);
        chk(fb(5), 8'h06);
        if (k == 60000) summarize;
    endtask

    initial begin
        num_errors = 0;
        num_checks = 0;
        rst = 1'b1;
        press = 1'b0;
        row_sel = 2'h0;
        col_sel = 2'h0;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        scan_all_keys;
        do_reset;
        normal_mode;
        display_mode;
        summarize;
    end
endmodule
